// ==== verilog/gdr_pkg.sv ====
// Constants and types shared by the group descriptor register model.
// Assumes one clock domain (mclk_i, 100 MHz) and a synchronous high reset.
//
// What this block does
// R1: First four group registers live only inside.
// R2: Device uses internal values, never shared copies.
// R3: Service request write makes device fetch copies.
// R4: DAC, status, global, queue descriptors shared.
// R5: Transmit slot and subchannel maps read ones.
// R6: Service request write taken as bus target.
// R7: Device wins bus, then accesses memory itself.
// R8: Internal registers writable before or after fetch.
// R9: Host fills memory first, then requests copy.
// R10: Host makes everything valid before channel activation.
// R11: Data moves follow the shared-memory descriptors.
// R12: Head and message pointers always read fresh.
// R13: Pointer tables at 0x000, 0x080, 0x100, 0x180.
// R14: Subchannel maps at 0x280 and 0x480.
// R15: Tx slot map 0x200, tx config 0x380.
// R16: Rx slot map 0x400, rx config 0x580.
// R17: Descriptors at 0x600 through 0x618.
// R18: Group base pointers are 2 kB aligned.
// R19: Host loads base pointers by bus writes.
// R20: Host provides one structure per group.
// R21: Map repeats every 0x800, request at 0x008.
// R22: Memory address is base plus structure offset.
package gdr_pkg;

    // ========================================================
    // Widths
    localparam int NGRP = 8;
    localparam int GW   = 3;
    localparam int OFFW = 11;
    localparam int AW   = 14;
    localparam int DW   = 32;
    localparam int RAMW = 12;
    localparam int HMW  = 12;

    // ========================================================
    // Device register map, per group
    localparam logic [AW-1:0]   GRP_STRIDE = 14'h0800;
    localparam logic [OFFW-1:0] OFF_BASE   = 11'h000;
    localparam logic [OFFW-1:0] OFF_DAC    = 11'h004;
    localparam logic [OFFW-1:0] OFF_SRQ    = 11'h008;
    localparam logic [OFFW-1:0] OFF_ISD    = 11'h00C;

    // ========================================================
    // Group structure offsets from the group base pointer
    localparam logic [OFFW-1:0] OFF_TXHP = 11'h000;
    localparam logic [OFFW-1:0] OFF_TXMP = 11'h080;
    localparam logic [OFFW-1:0] OFF_RXHP = 11'h100;
    localparam logic [OFFW-1:0] OFF_RXMP = 11'h180;
    localparam logic [OFFW-1:0] OFF_TXTS = 11'h200; // R15
    localparam logic [OFFW-1:0] OFF_TXSC = 11'h280; // R14
    localparam logic [OFFW-1:0] OFF_TXCC = 11'h380;
    localparam logic [OFFW-1:0] OFF_RXTS = 11'h400; // R16
    localparam logic [OFFW-1:0] OFF_RXSC = 11'h480;
    localparam logic [OFFW-1:0] OFF_RXCC = 11'h580;
    localparam logic [OFFW-1:0] OFF_GCD  = 11'h600; // R17
    localparam logic [OFFW-1:0] OFF_IQD  = 11'h604;
    localparam logic [OFFW-1:0] OFF_GRC  = 11'h60C;
    localparam logic [OFFW-1:0] OFF_MPD  = 11'h610;
    localparam logic [OFFW-1:0] OFF_MLD  = 11'h614;
    localparam logic [OFFW-1:0] OFF_PCD  = 11'h618;
    localparam logic [OFFW-1:0] WORD_STEP = 11'h004;

    // ========================================================
    // Values
    localparam logic [DW-1:0]   ALL_ONES   = 32'hFFFFFFFF;
    localparam logic [DW-1:0]   BASE_MASK  = 32'hFFFFF800;
    localparam logic [DW-1:0]   RST_WORD   = 32'h00000000;

    // ========================================================
    // State types
    typedef enum logic [1:0] {DS_IDLE, DS_FETCH, DS_USER} gdr_dst_t;
    typedef enum logic [1:0] {MS_IDLE, MS_ARB, MS_XFER} gdr_mst_t;
    typedef enum logic {HS_IDLE, HS_WAIT} gdr_hst_t;

endpackage

// ==== verilog/gdr_bus_if.sv ====
// Host bus between the host processor end and the device end.
// Assumes both ends run on the same clock; target and master groups.
`timescale 1ns/1ps
interface gdr_bus_if;
    import gdr_pkg::*;

    // Target group: host reaches the device register map
    logic            t_req;
    logic            t_we;
    logic [AW-1:0]   t_addr;
    logic [DW-1:0]   t_wdata;
    logic            t_ack;
    logic [DW-1:0]   t_rdata;
    // Master group: device reaches host shared memory
    logic            m_req;
    logic            m_gnt;
    logic            m_stb;
    logic            m_we;
    logic [DW-1:0]   m_addr;
    logic [DW-1:0]   m_wdata;
    logic            m_ack;
    logic [DW-1:0]   m_rdata;

    modport dev (
        input  t_req, t_we, t_addr, t_wdata, m_gnt, m_ack, m_rdata,
        output t_ack, t_rdata, m_req, m_stb, m_we, m_addr, m_wdata
    );
    modport host (
        output t_req, t_we, t_addr, t_wdata, m_gnt, m_ack, m_rdata,
        input  t_ack, t_rdata, m_req, m_stb, m_we, m_addr, m_wdata
    );
endinterface

// ==== verilog/gdr_mst.sv ====
// Bus master engine: requests the bus, waits for grant, does one access.
// Assumes the host grants and acknowledges on the same clock.
`timescale 1ns/1ps
module gdr_mst
    import gdr_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          srst_i,
    input  wire logic          go_i,
    input  wire logic          we_i,
    input  wire logic [DW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic               done_o,
    output logic [DW-1:0]      rdata_o,
    output logic               req_o,
    output logic               stb_o,
    output logic               we_o,
    output logic [DW-1:0]      addr_o,
    output logic [DW-1:0]      wdata_o,
    input  wire logic          gnt_i,
    input  wire logic          ack_i,
    input  wire logic [DW-1:0] rdata_i
);
    gdr_mst_t st_r;

    // ========================================================
    // Arbitration and transfer sequence
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_r    <= MS_IDLE;
            req_o   <= 1'b0;
            stb_o   <= 1'b0;
            we_o    <= 1'b0;
            addr_o  <= RST_WORD;
            wdata_o <= RST_WORD;
            done_o  <= 1'b0;
            rdata_o <= RST_WORD;
        end else begin
            done_o <= 1'b0;
            unique case (st_r)
                MS_IDLE: begin
                    if (go_i) begin
                        req_o   <= 1'b1;           // R7
                        we_o    <= we_i;
                        addr_o  <= addr_i;
                        wdata_o <= wdata_i;
                        st_r    <= MS_ARB;
                    end
                end
                MS_ARB: begin
                    if (gnt_i) begin
                        stb_o <= 1'b1;             // R7
                        st_r  <= MS_XFER;
                    end
                end
                MS_XFER: begin
                    if (ack_i) begin
                        stb_o   <= 1'b0;
                        req_o   <= 1'b0;
                        rdata_o <= rdata_i;
                        done_o  <= 1'b1;
                        st_r    <= MS_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// ==== verilog/gdr_dev.sv ====
// Device end: internal group registers, image RAM and service request fetch.
// Assumes the host end drives the target group and grants the master group.
`timescale 1ns/1ps
module gdr_dev
    import gdr_pkg::*;
(
    input  wire logic            mclk_i,
    input  wire logic            srst_i,
    gdr_bus_if.dev               bus,
    input  wire logic            usr_req_i,
    input  wire logic            usr_we_i,
    input  wire logic [GW-1:0]   usr_grp_i,
    input  wire logic [OFFW-1:0] usr_off_i,
    input  wire logic [DW-1:0]   usr_wdata_i,
    output logic                 usr_done_o,
    output logic [DW-1:0]        usr_rdata_o,
    output logic                 fetch_done_o,
    output logic [GW-1:0]        fetch_grp_o,
    input  wire logic [GW-1:0]   cfg_grp_i,
    input  wire logic [OFFW-1:0] cfg_off_i,
    output logic [DW-1:0]        cfg_rdata_o,
    output logic                 busy_o
);
    gdr_dst_t             st_r;
    logic [DW-1:0]        base_r [NGRP];
    logic [DW-1:0]        srq_r  [NGRP];
    logic [DW-1:0]        dac_r;
    logic [DW-1:0]        isd_r;
    logic [NGRP-1:0]      srq_pend_r;
    logic [DW-1:0]        img_mem [2**RAMW];
    logic [GW-1:0]        grp_r;
    logic [GW-1:0]        ugrp_r;
    logic [OFFW-1:0]      off_r;
    logic                 usr_pend_r;
    logic                 usr_we_r;
    logic [DW-1:0]        usr_wdata_r;
    logic                 t_ack_r;
    logic [DW-1:0]        t_rdata_r;
    logic                 mgo_r;
    logic                 m_done;
    logic [DW-1:0]        m_rdata;
    logic                 fetch_wr;
    logic                 tgt_go;
    logic [GW-1:0]        t_grp;
    logic [OFFW-1:0]      t_off;
    logic                 t_img_wr;
    logic [NGRP-1:0]      srq_set;
    logic [GW-1:0]        pick_grp;
    logic                 pick_any;

    // Shared descriptors live in the group 0 slot
    function automatic logic [RAMW-1:0] img_idx(input logic [GW-1:0] g,
                                                input logic [OFFW-1:0] o);
        if (o >= OFF_GCD && o < OFF_GRC)
            img_idx = {{GW{1'b0}}, o[OFFW-1:2]};                  // R4
        else
            img_idx = {g, o[OFFW-1:2]};
    endfunction

    // ========================================================
    // Target decode
    assign t_grp    = bus.t_addr[AW-1:OFFW];                      // R21
    assign t_off    = bus.t_addr[OFFW-1:0];
    assign fetch_wr = (st_r == DS_FETCH) && m_done;
    assign tgt_go   = bus.t_req && !t_ack_r && !fetch_wr;         // R6
    // Only transmit maps take direct writes
    assign t_img_wr = tgt_go && bus.t_we && t_off >= OFF_TXTS
                      && t_off < OFF_TXCC;                        // R2 R5

    // Lowest pending group is served first
    always_comb begin
        pick_grp = '0;
        pick_any = 1'b0;
        for (int i = NGRP - 1; i >= 0; i--) begin
            if (srq_pend_r[i]) begin
                pick_grp = GW'(i);
                pick_any = 1'b1;
            end
        end
    end

    // Service request writes per group
    genvar g;
    generate
        for (g = 0; g < NGRP; g++) begin : grp_regs
            assign srq_set[g] = tgt_go && bus.t_we && t_off == OFF_SRQ
                                && t_grp == GW'(g);
            // Base pointer and service request held internally only
            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    base_r[g] <= RST_WORD;
                    srq_r[g]  <= RST_WORD;
                end else if (tgt_go && bus.t_we && t_grp == GW'(g)) begin
                    if (t_off == OFF_BASE)
                        base_r[g] <= bus.t_wdata;                 // R1 R8
                    if (t_off == OFF_SRQ)
                        srq_r[g] <= bus.t_wdata;                  // R1 R6
                end
            end
            // Pending flag: a new request wins over the clear
            always_ff @(posedge mclk_i) begin
                if (srst_i)
                    srq_pend_r[g] <= 1'b0;
                else if (srq_set[g])
                    srq_pend_r[g] <= 1'b1;                        // R3
                else if (st_r == DS_IDLE && pick_grp == GW'(g)
                         && pick_any)
                    srq_pend_r[g] <= 1'b0;
            end
        end
    endgenerate

    // Registers common to all groups
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dac_r <= RST_WORD;
            isd_r <= RST_WORD;
        end else if (tgt_go && bus.t_we) begin
            if (t_off == OFF_DAC)
                dac_r <= bus.t_wdata;                             // R4
            if (t_off == OFF_ISD)
                isd_r <= bus.t_wdata;                             // R4
        end
    end

    // ========================================================
    // Image RAM: fetched words win
    always_ff @(posedge mclk_i) begin
        if (fetch_wr)
            img_mem[img_idx(grp_r, off_r)] <= m_rdata;            // R3
        else if (t_img_wr)
            img_mem[img_idx(t_grp, t_off)] <= bus.t_wdata;        // R5
    end

    // Target answer, one cycle after the request is taken
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            t_ack_r   <= 1'b0;
            t_rdata_r <= RST_WORD;
        end else begin
            t_ack_r <= tgt_go;
            if (tgt_go) begin
                if (t_off == OFF_BASE)
                    t_rdata_r <= base_r[t_grp];                   // R1
                else if (t_off == OFF_DAC)
                    t_rdata_r <= dac_r;
                else if (t_off == OFF_SRQ)
                    t_rdata_r <= srq_r[t_grp];
                else if (t_off == OFF_ISD)
                    t_rdata_r <= isd_r;
                else if (t_off >= OFF_TXTS && t_off < OFF_TXCC)
                    t_rdata_r <= ALL_ONES;                        // R5
                else if (t_off >= OFF_TXCC && t_off <= OFF_PCD)
                    t_rdata_r <= img_mem[img_idx(t_grp, t_off)];
                else
                    t_rdata_r <= RST_WORD;
            end
        end
    end
    assign bus.t_ack   = t_ack_r;
    assign bus.t_rdata = t_rdata_r;

    // Internal value seen by channel logic
    always_ff @(posedge mclk_i) begin
        if (srst_i)
            cfg_rdata_o <= RST_WORD;
        else
            cfg_rdata_o <= img_mem[img_idx(cfg_grp_i, cfg_off_i)]; // R2
    end

    // ========================================================
    // Fetch and channel access sequencer
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_r         <= DS_IDLE;
            grp_r        <= '0;
            off_r        <= '0;
            mgo_r        <= 1'b0;
            usr_pend_r   <= 1'b0;
            usr_we_r     <= 1'b0;
            usr_wdata_r  <= RST_WORD;
            usr_done_o   <= 1'b0;
            usr_rdata_o  <= RST_WORD;
            fetch_done_o <= 1'b0;
            fetch_grp_o  <= '0;
            busy_o       <= 1'b0;
        end else begin
            mgo_r        <= 1'b0;
            usr_done_o   <= 1'b0;
            fetch_done_o <= 1'b0;
            if (usr_req_i && !usr_pend_r && st_r != DS_USER) begin
                usr_pend_r  <= 1'b1;
                usr_we_r    <= usr_we_i;
                usr_wdata_r <= usr_wdata_i;
            end
            unique case (st_r)
                DS_IDLE: begin
                    if (pick_any) begin
                        grp_r <= pick_grp;
                        off_r <= OFF_TXTS;
                        mgo_r <= 1'b1;                            // R3
                        st_r  <= DS_FETCH;
                    end else if (usr_pend_r) begin
                        grp_r <= ugrp_r;
                        mgo_r <= 1'b1;                            // R11
                        st_r  <= DS_USER;
                    end
                end
                DS_FETCH: begin
                    if (m_done) begin
                        if (off_r == OFF_PCD) begin
                            fetch_done_o <= 1'b1;
                            fetch_grp_o  <= grp_r;
                            st_r         <= DS_IDLE;
                        end else begin
                            off_r <= off_r + WORD_STEP;
                            mgo_r <= 1'b1;
                        end
                    end
                end
                DS_USER: begin
                    if (m_done) begin
                        usr_pend_r  <= 1'b0;
                        usr_done_o  <= 1'b1;
                        usr_rdata_o <= m_rdata;                   // R12
                        st_r        <= DS_IDLE;
                    end
                end
            endcase
            busy_o <= (st_r != DS_IDLE) || pick_any || usr_pend_r;
        end
    end

    // Latch the channel group and offset when the request is taken
    logic [OFFW-1:0] uoff_r;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            uoff_r <= '0;
            ugrp_r <= '0;
        end else if (usr_req_i && !usr_pend_r && st_r != DS_USER) begin
            uoff_r <= usr_off_i;
            ugrp_r <= usr_grp_i;
        end
    end

    // ========================================================
    // Master engine; address is base pointer plus structure offset
    gdr_mst u_mst (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .go_i    (mgo_r),
        .we_i    (st_r == DS_USER && usr_we_r),
        .addr_i  (base_r[grp_r] + {21'h000000,
                  (st_r == DS_USER) ? uoff_r : off_r}),           // R22 R13
        .wdata_i (usr_wdata_r),
        .done_o  (m_done),
        .rdata_o (m_rdata),
        .req_o   (bus.m_req),
        .stb_o   (bus.m_stb),
        .we_o    (bus.m_we),
        .addr_o  (bus.m_addr),
        .wdata_o (bus.m_wdata),
        .gnt_i   (bus.m_gnt),
        .ack_i   (bus.m_ack),
        .rdata_i (bus.m_rdata)
    );
endmodule

// ==== verilog/gdr_host.sv ====
// Host end: issues register accesses, grants the bus, serves shared memory.
// Assumes the device end answers each target request with one ack pulse.
`timescale 1ns/1ps
module gdr_host
    import gdr_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          srst_i,
    gdr_bus_if.host            bus,
    input  wire logic          cmd_req_i,
    input  wire logic          cmd_we_i,
    input  wire logic [AW-1:0] cmd_addr_i,
    input  wire logic [DW-1:0] cmd_wdata_i,
    output logic               cmd_done_o,
    output logic [DW-1:0]      cmd_rdata_o,
    output logic               busy_o,
    input  wire logic          mem_we_i,
    input  wire logic [DW-1:0] mem_addr_i,
    input  wire logic [DW-1:0] mem_wdata_i
);
    gdr_hst_t        st_r;
    logic [DW-1:0]   shm [2**HMW];
    logic            t_req_r;
    logic            t_we_r;
    logic [AW-1:0]   t_addr_r;
    logic [DW-1:0]   t_wdata_r;
    logic            gnt_r;
    logic            ack_r;
    logic [DW-1:0]   rdata_r;
    logic            serve;

    // ========================================================
    // Register access; base pointers 2 kB aligned
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_r        <= HS_IDLE;
            t_req_r     <= 1'b0;
            t_we_r      <= 1'b0;
            t_addr_r    <= '0;
            t_wdata_r   <= RST_WORD;
            cmd_done_o  <= 1'b0;
            cmd_rdata_o <= RST_WORD;
            busy_o      <= 1'b0;
        end else begin
            cmd_done_o <= 1'b0;
            unique case (st_r)
                HS_IDLE: begin
                    if (cmd_req_i) begin
                        t_req_r  <= 1'b1;                         // R19 R3
                        t_we_r   <= cmd_we_i;
                        t_addr_r <= cmd_addr_i;
                        if (cmd_addr_i[OFFW-1:0] == OFF_BASE)
                            t_wdata_r <= cmd_wdata_i & BASE_MASK; // R18
                        else
                            t_wdata_r <= cmd_wdata_i;
                        busy_o   <= 1'b1;
                        st_r     <= HS_WAIT;
                    end
                end
                HS_WAIT: begin
                    if (bus.t_ack) begin
                        t_req_r     <= 1'b0;
                        cmd_rdata_o <= bus.t_rdata;
                        cmd_done_o  <= 1'b1;
                        busy_o      <= 1'b0;
                        st_r        <= HS_IDLE;
                    end
                end
            endcase
        end
    end
    assign bus.t_req   = t_req_r;
    assign bus.t_we    = t_we_r;
    assign bus.t_addr  = t_addr_r;
    assign bus.t_wdata = t_wdata_r;

    // ========================================================
    // Shared memory; user loads stall the device strobe
    assign serve = bus.m_stb && !ack_r && !mem_we_i;              // R20 R9

    always_ff @(posedge mclk_i) begin
        if (mem_we_i)
            shm[mem_addr_i[HMW+1:2]] <= mem_wdata_i;              // R10
        else if (serve && bus.m_we)
            shm[bus.m_addr[HMW+1:2]] <= bus.m_wdata;
    end

    // Grant follows request; ack one cycle after a served strobe
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            gnt_r   <= 1'b0;
            ack_r   <= 1'b0;
            rdata_r <= RST_WORD;
        end else begin
            gnt_r <= bus.m_req;
            ack_r <= serve;
            if (serve)
                rdata_r <= shm[bus.m_addr[HMW+1:2]];
        end
    end
    assign bus.m_gnt   = gnt_r;
    assign bus.m_ack   = ack_r;
    assign bus.m_rdata = rdata_r;
endmodule

// ==== tb/gdr_bus_assertions.sv ====
// Host bus assertions.
// Assumes one clock; instantiated by the bench.
`timescale 1ns/1ps
module gdr_bus_assertions
    import gdr_pkg::*;
(
    input  wire logic          mclk_i,
    input  wire logic          srst_i,
    input  wire logic          t_req,
    input  wire logic          t_we,
    input  wire logic [AW-1:0] t_addr,
    input  wire logic          t_ack,
    input  wire logic [DW-1:0] t_rdata,
    input  wire logic          m_req,
    input  wire logic          m_gnt,
    input  wire logic          m_stb,
    input  wire logic [DW-1:0] m_addr,
    input  wire logic          m_ack
);
    // ==========================================================
    // Target side
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    tack_one_cycle_a: assert property (t_ack |=> !t_ack)
        else $error("ack too long");
    tack_with_req_a: assert property (t_ack |-> t_req)
        else $error("stray ack");
    tack_bounded_a: assert property ($rose(t_req) |-> ##[1:3] t_ack)
        else $error("no ack");
    txmap_reads_ones_a: assert property (
        t_ack && !t_we && t_addr[10:0] >= 11'h200 && t_addr[10:0] < 11'h380
        |-> t_rdata == ALL_ONES)
        else $error("map read not ones");
    srq_starts_fetch_a: assert property (
        t_ack && t_we && t_addr[10:0] == OFF_SRQ |-> ##[1:8] m_req)
        else $error("no fetch");
    // ==========================================================
    // Master side
    gnt_after_req_a: assert property (m_gnt |-> $past(m_req))
        else $error("stray grant");
    stb_needs_gnt_a: assert property (m_stb |-> m_gnt)
        else $error("stb without gnt");
    stb_held_a: assert property (
        m_stb && !m_ack |=> m_stb && $stable(m_addr))
        else $error("stb dropped");
    mack_with_stb_a: assert property (m_ack |-> m_stb)
        else $error("stray m_ack");
endmodule

// ==== tb/group_descriptor_register_model_tb.sv ====
// Bench: host and device ends on one bus.
// Assumes the design files compiled first.
`timescale 1ns/1ps
module group_descriptor_register_model_tb;
    import gdr_pkg::*;
    // ==========================================================
    // Signals
    logic mclk_i, srst_i, cmd_req, cmd_we, cmd_done, h_busy, mem_we;
    logic usr_req, usr_we, usr_done, fetch_done, d_busy;
    logic [AW-1:0]   cmd_addr;
    logic [DW-1:0]   cmd_wdata, cmd_rdata, mem_addr, mem_wdata;
    logic [DW-1:0]   usr_wdata, usr_rdata, cfg_rdata;
    logic [GW-1:0]   usr_grp, fetch_grp, cfg_grp;
    logic [OFFW-1:0] usr_off, cfg_off;
    logic [OFFW-1:0] offs [9] = '{OFF_TXTS, OFF_TXSC, OFF_TXCC, OFF_RXTS,
        OFF_RXSC, OFF_RXCC, OFF_GRC, OFF_MPD, OFF_PCD};
    int err_total, check_count;
    gdr_bus_if gdr_bus_if_i ();
    gdr_host gdr_host_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .bus(gdr_bus_if_i), .cmd_req_i(cmd_req), .cmd_we_i(cmd_we),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
        .cmd_done_o(cmd_done), .cmd_rdata_o(cmd_rdata), .busy_o(h_busy),
        .mem_we_i(mem_we), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata));
    gdr_dev gdr_dev_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .bus(gdr_bus_if_i), .usr_req_i(usr_req), .usr_we_i(usr_we),
        .usr_grp_i(usr_grp), .usr_off_i(usr_off), .usr_wdata_i(usr_wdata),
        .usr_done_o(usr_done), .usr_rdata_o(usr_rdata),
        .fetch_done_o(fetch_done), .fetch_grp_o(fetch_grp),
        .cfg_grp_i(cfg_grp), .cfg_off_i(cfg_off), .cfg_rdata_o(cfg_rdata),
        .busy_o(d_busy));
    gdr_bus_assertions gdr_bus_assertions_i (.mclk_i(mclk_i),
        .srst_i(srst_i), .t_req(gdr_bus_if_i.t_req),
        .t_we(gdr_bus_if_i.t_we), .t_addr(gdr_bus_if_i.t_addr),
        .t_ack(gdr_bus_if_i.t_ack), .t_rdata(gdr_bus_if_i.t_rdata),
        .m_req(gdr_bus_if_i.m_req), .m_gnt(gdr_bus_if_i.m_gnt),
        .m_stb(gdr_bus_if_i.m_stb), .m_addr(gdr_bus_if_i.m_addr),
        .m_ack(gdr_bus_if_i.m_ack));
    // ==========================================================
    // Clock, watchdog and helpers
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    initial begin
        #300000;
        err_total++;
        summarize();
    end
    function automatic logic [DW-1:0] pat(input logic [OFFW-1:0] o);
        return {16'hA5C3, 5'h00, o};
    endfunction
    function automatic logic sel(input int k);
        return (k == 0) ? cmd_done : (k == 1) ? usr_done : fetch_done;
    endfunction
    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Wait for a completion pulse under a cycle limit
    task automatic wait_for(input int k, input int lim);
        int n;
        n = 0;
        while (sel(k) !== 1'b1 && n < lim) begin
            @(posedge mclk_i); #1;
            n++;
        end
        if (n >= lim) begin
            err_total++;
            $display("BAD %0t timeout", $time);
        end
    endtask
    task automatic hcmd(input logic w, input logic [AW-1:0] a,
                        input logic [DW-1:0] d);
        cmd_req = 1'b1; cmd_we = w; cmd_addr = a; cmd_wdata = d;
        @(posedge mclk_i); #1;
        cmd_req = 1'b0;
        wait_for(0, 40);
    endtask
    task automatic ucmd(input logic w, input logic [GW-1:0] g,
                        input logic [OFFW-1:0] o, input logic [DW-1:0] d);
        usr_req = 1'b1; usr_we = w; usr_grp = g; usr_off = o; usr_wdata = d;
        @(posedge mclk_i); #1;
        usr_req = 1'b0;
        wait_for(1, 60);
    endtask
    task automatic mw(input logic [DW-1:0] a, input logic [DW-1:0] d);
        mem_we = 1'b1; mem_addr = a; mem_wdata = d;
        @(posedge mclk_i); #1;
        mem_we = 1'b0;
        @(posedge mclk_i); #1;
    endtask
    task automatic cfg(input logic [GW-1:0] g, input logic [OFFW-1:0] o,
                       input logic [DW-1:0] exp);
        cfg_grp = g; cfg_off = o;
        @(posedge mclk_i); #1;
        chk(cfg_rdata, exp);
    endtask
    // ==========================================================
    // Test sequence
    initial begin
        {cmd_req, cmd_we, mem_we, usr_req, usr_we} = 5'h00;
        {cmd_addr, cmd_wdata, mem_addr, mem_wdata, usr_wdata} = '0;
        {usr_grp, usr_off, cfg_grp, cfg_off} = '0;
        srst_i = 1'b1;
        repeat (16) @(posedge mclk_i);
        #1 srst_i = 1'b0;
        hcmd(1'b1, 14'h0800, 32'h00000ABC);
        hcmd(1'b0, 14'h0800, 32'h00000000);
        chk(cmd_rdata, 32'h00000800);
        $display("end base test");
        for (int o = 'h200; o <= 'h618; o += 4) mw(32'h800 + o, pat(11'(o)));
        hcmd(1'b1, 14'h0808, 32'h00000001);
        wait_for(2, 3000);
        chk({29'h0, fetch_grp}, 32'h00000001);
        for (int i = 0; i < 9; i++) cfg(3'h1, offs[i], pat(offs[i]));
        cfg(3'h0, OFF_GCD, pat(OFF_GCD));
        mw(32'h00000E0C, 32'h00000000);
        cfg(3'h1, OFF_GRC, pat(OFF_GRC));
        $display("end fetch test");
        hcmd(1'b0, 14'h0A00, 32'h00000000);
        chk(cmd_rdata, ALL_ONES);
        hcmd(1'b0, 14'h0A84, 32'h00000000);
        chk(cmd_rdata, ALL_ONES);
        $display("end map test");
        ucmd(1'b1, 3'h1, OFF_RXMP, 32'h12345678);
        ucmd(1'b0, 3'h1, OFF_RXMP, 32'h00000000);
        chk(usr_rdata, 32'h12345678);
        mw(32'h00000980, 32'h5A5A0001);
        ucmd(1'b0, 3'h1, OFF_RXMP, 32'h00000000);
        chk(usr_rdata, 32'h5A5A0001);
        mw(32'h00001080, 32'h3C3C0002);
        hcmd(1'b1, 14'h0800, 32'h00001000);
        ucmd(1'b0, 3'h1, OFF_TXMP, 32'h00000000);
        chk(usr_rdata, 32'h3C3C0002);
        $display("end access test");
        summarize();
    end
endmodule
